// ===== verilog/pmsl_regs.svh
`ifndef PMSL_REGS_SVH
`define PMSL_REGS_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define PMSL_CLK_KHZ 100000
`define PMSL_STRETCH_MS 25
`define PMSL_LOCKUP_MS 35
// longest stretch and lock-up limit both come out as whole cycles
`define PMSL_STRETCH_CYC (`PMSL_STRETCH_MS * `PMSL_CLK_KHZ)
`define PMSL_LOCKUP_CYC (`PMSL_LOCKUP_MS * `PMSL_CLK_KHZ)
`define PMSL_CNT_W 22
// supported bus rates, standard is the default
`define PMSL_STD_KHZ 100
`define PMSL_FAST_KHZ 400

// ------------------------------------------------------------
// addressing, command ranges, check byte
// ------------------------------------------------------------
`define PMSL_CTRL_PFX 4'hB
`define PMSL_MEM_PFX 4'hA
`define PMSL_BCAST_ADDR 8'h00
`define PMSL_VENDOR_LO 8'hD0
`define PMSL_VENDOR_HI 8'hEF
`define PMSL_CRC_POLY 8'h07
`define PMSL_IDLE_BYTE 8'hFF
`define PMSL_BYTE_BITS 4'h8
`define PMSL_LAST_BIT 4'h7
`define PMSL_BLOCK_MAX 48
`define PMSL_FIFO_DEPTH 16
`define PMSL_VOUT_EXP 9

`endif

// ===== verilog/pmsl_pkg.sv
`include "pmsl_regs.svh"

package pmsl_pkg;

    // one-hot bus receiver states
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX   = 6'h02,
        ST_ACK  = 6'h04,
        ST_TX   = 6'h08,
        ST_RACK = 6'h10,
        ST_HOLD = 6'h20
    } pmsl_state_e;

    // one received byte as handed to the command logic
    typedef struct packed {
        logic [7:0] data;
        logic cmd;
        logic vendor;
        logic bcast;
        logic crc_ok;
    } pmsl_rx_s;

    // one byte to return on a read
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } pmsl_tx_s;

    // alert trigger classes, levels
    typedef struct packed {
        logic vin_fault;
        logic vout_fault;
        logic iout_oc;
        logic temp;
        logic fan;
        logic comm_err;
        logic pec_err;
        logic bad_cmd;
        logic internal;
    } pmsl_ev_s;

    // packed value word: five-bit exponent over eleven-bit mantissa
    typedef struct packed {
        logic signed [4:0] exponent;
        logic signed [10:0] mantissa;
    } pmsl_linear_s;

    // output voltage words are a plain mantissa with a fixed exponent
    typedef logic [15:0] pmsl_vout_t;

    typedef struct packed {
        pmsl_state_e st;
        logic scl_m;
        logic scl;
        logic scl_q;
        logic sda_m;
        logic sda;
        logic sda_q;
        logic [2:0] asel_m;
        logic [2:0] asel;
        logic en_m;
        logic en;
        logic en_q;
        logic op_q;
        logic [3:0] bits;
        logic [7:0] sh;
        logic is_addr;
        logic is_cmd;
        logic rw;
        logic bcast;
        logic in_xfer;
        logic to_tx;
        logic pec_pend;
        logic mack;
        logic [7:0] crc;
        logic sda_oe;
        logic scl_oe;
        logic low;
        logic [`PMSL_CNT_W-1:0] hold_cnt;
        logic [`PMSL_CNT_W-1:0] low_cnt;
        logic push;
        pmsl_rx_s pdata;
        logic tx_rdy;
        pmsl_ev_s ev_q;
        logic alert_n;
        logic comm;
    } pmsl_core_s;

endpackage

// ===== verilog/pmsl_slave.sv
`timescale 1ns/100ps
`include "pmsl_regs.svh"

// ------------------------------------------------------------
// receive buffer
// ------------------------------------------------------------
module pmsl_fifo #(
    parameter int W = 12,
    parameter int D = 16
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] od;
        logic ir;
    } pmsl_fifo_st_s;

    logic [W-1:0] mem [D];
    pmsl_fifo_st_s s;
    pmsl_fifo_st_s next_s;
    logic push;
    logic load;

    // output word sits in a register so the reader sees flop outputs
    always_comb begin
        next_s = s;
        push = in_valid_i && s.ir;
        load = (s.cnt != '0) && (!s.ov || out_ready_i);
        if (push) begin
            next_s.wp = s.wp + 1'b1;
        end
        if (load) begin
            next_s.od = mem[s.rp];
            next_s.ov = 1'b1;
            next_s.rp = s.rp + 1'b1;
        end else if (out_ready_i) begin
            next_s.ov = 1'b0;
        end
        next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(load);
        // ready looks at the count after this edge, so a push never overruns
        next_s.ir = next_s.cnt < (AW+1)'(D);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // storage has no reset; the count guards every read
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[s.wp] <= in_data_i;
        end
    end

    assign in_ready_o = s.ir;
    assign out_valid_o = s.ov;
    assign out_data_o = s.od;
endmodule

// ------------------------------------------------------------
// management bus slave
// ------------------------------------------------------------
// What this block does
// RULE_01: acts purely as slave; never starts transfers, only holds clock low.
// RULE_02: clock stretch while busy never exceeds 25 ms.
// RULE_03: host waits out any stretch or delays beyond its maximum.
// RULE_04: stretch starts only after the ninth acknowledge bit, or at start.
// RULE_05: bus held low over 35 ms aborts transfer and releases both lines.
// RULE_06: works at 100 kHz and 400 kHz; 100 kHz is default.
// RULE_07: commands accepted and executed with or without trailing check byte.
// RULE_08: check byte is CRC-8 with polynomial x^8+x^2+x+1.
// RULE_09: CRC covers every byte including write address before repeated start.
// RULE_10: whoever sends the final data byte appends the check byte.
// RULE_11: alert idles high, goes low on any state change, stays latched; the code pulls it low only when a trigger bit rises, not when one falls.
// RULE_12: alert reasserts after clearing if the alarm condition still exists.
// RULE_13: triggers cover voltage, current, temperature, fan, bus, CRC, command, internal.
// RULE_14: alert released by clear-faults, output recycling, or status word read.
// RULE_15: host broadcasts writes only, then reads each supply back.
// RULE_16: host waits over 2 seconds after alert before reading status.
// RULE_17: host reads one device no more than once per second.
// RULE_18: standard write: address, command, up to two data bytes, optional check.
// RULE_19: standard read: command, repeated start, low, high, check, host nacks.
// RULE_20: over two bytes use block framing with count, up to 48 bytes.
// RULE_21: value words carry five-bit exponent over eleven-bit two's-complement mantissa.
// RULE_22: output voltage words use sixteen-bit mantissa with fixed exponent.
// RULE_23: vendor command codes from D0 to EF are recognised.
// RULE_24: controller answers prefix 1011 plus pin bits; all-zero address is write broadcast.
// RULE_25: after lock-up abort, wait for a fresh start before taking bytes.
module pmsl_slave #(
    parameter int STRETCH_CYC = `PMSL_STRETCH_CYC,
    parameter int LOCKUP_CYC = `PMSL_LOCKUP_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_select_bit2_i,
    input wire logic addr_select_bit1_i,
    input wire logic addr_select_bit0_i,
    input wire logic output_enable_pin_i,
    input wire logic op_on_i,
    input wire logic clear_faults_i,
    input wire logic status_word_read_i,
    input wire pmsl_pkg::pmsl_ev_s ev_i,
    output logic rx_valid_o,
    output pmsl_pkg::pmsl_rx_s rx_data_o,
    input wire logic rx_ready_i,
    input wire logic tx_valid_i,
    input wire pmsl_pkg::pmsl_tx_s tx_data_i,
    output logic tx_ready_o,
    output logic alert_n_o
);
    localparam int CW = `PMSL_CNT_W;

    pmsl_pkg::pmsl_core_s s;
    pmsl_pkg::pmsl_core_s next_s;
    pmsl_pkg::pmsl_ev_s ev;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic lockup;
    logic clr;
    logic ev_rise;
    logic fifo_ready;
    logic [7:0] tx_byte;

    // bitwise CRC-8 over one byte, shared by receive and transmit paths
    function automatic logic [7:0] pmsl_crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ `PMSL_CRC_POLY) : {r[6:0], 1'b0}; // RULE_08
        end
        return r;
    endfunction

    // edges seen at 100 MHz, far faster than either bus rate
    assign rise = s.scl && !s.scl_q; // RULE_06
    assign fall = !s.scl && s.scl_q;
    assign start_c = s.scl && s.scl_q && s.sda_q && !s.sda;
    assign stop_c = s.scl && s.scl_q && !s.sda_q && s.sda;
    assign lockup = s.low_cnt == CW'(LOCKUP_CYC - 1);

    // internal bus abort counts as a communication error
    always_comb begin
        ev = ev_i;
        ev.comm_err = ev_i.comm_err || s.comm; // RULE_13
    end

    assign ev_rise = |(ev & ~s.ev_q);
    assign clr = clear_faults_i || status_word_read_i || (s.en && !s.en_q) || (op_on_i && !s.op_q);
    assign tx_byte = s.pec_pend ? s.crc :
        (tx_valid_i && s.tx_rdy ? tx_data_i.data : `PMSL_IDLE_BYTE); // RULE_21 RULE_22

    // ------------------------------------------------------------
    // bus engine and alert latch
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.push = 1'b0;
        next_s.comm = 1'b0;
        // pins pass two flops before anything looks at them
        next_s.scl_m = scl_i;
        next_s.scl = s.scl_m;
        next_s.scl_q = s.scl;
        next_s.sda_m = sda_i;
        next_s.sda = s.sda_m;
        next_s.sda_q = s.sda;
        next_s.asel_m = {addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i};
        next_s.asel = s.asel_m;
        next_s.en_m = output_enable_pin_i;
        next_s.en = s.en_m;
        next_s.en_q = s.en;
        next_s.op_q = op_on_i;
        next_s.ev_q = ev;

        // a line stuck low counts; any clock rise or both high restarts it
        if ((s.scl && s.sda) || rise) begin
            next_s.low_cnt = '0;
        end else if (!lockup) begin
            next_s.low_cnt = s.low_cnt + 1'b1;
        end

        if (lockup) begin
            next_s.st = pmsl_pkg::ST_IDLE; // RULE_05
            next_s.sda_oe = 1'b0;
            next_s.scl_oe = 1'b0;
            next_s.in_xfer = 1'b0; // RULE_25
            next_s.tx_rdy = 1'b0;
            next_s.comm = 1'b1;
        end else if (stop_c) begin
            next_s.st = pmsl_pkg::ST_IDLE;
            next_s.sda_oe = 1'b0;
            next_s.scl_oe = 1'b0;
            next_s.in_xfer = 1'b0;
            next_s.tx_rdy = 1'b0;
        end else if (start_c) begin
            // a repeated start keeps the running check so reads cover the write part
            next_s.st = pmsl_pkg::ST_RX;
            next_s.bits = '0;
            next_s.is_addr = 1'b1;
            next_s.sda_oe = 1'b0;
            next_s.scl_oe = 1'b0;
            next_s.tx_rdy = 1'b0;
            next_s.pec_pend = 1'b0;
            if (!s.in_xfer) begin
                next_s.crc = '0; // RULE_09
            end
            next_s.in_xfer = 1'b1;
        end else begin
            case (s.st)
                pmsl_pkg::ST_IDLE: begin
                    next_s.sda_oe = 1'b0; // RULE_25
                end
                pmsl_pkg::ST_RX: begin
                    next_s.scl_oe = 1'b0;
                    if (rise) begin
                        next_s.sh = {s.sh[6:0], s.sda};
                        next_s.bits = s.bits + 1'b1;
                    end
                    if (fall && s.bits == `PMSL_BYTE_BITS) begin
                        next_s.crc = pmsl_crc8(s.crc, s.sh); // RULE_09
                        if (s.is_addr) begin
                            // memory prefix belongs to the separate store, not here
                            next_s.bcast = s.sh == `PMSL_BCAST_ADDR;
                            next_s.rw = s.sh[0];
                            if (s.sh[7:1] == {`PMSL_CTRL_PFX, s.asel} ||
                                s.sh == `PMSL_BCAST_ADDR) begin
                                next_s.st = pmsl_pkg::ST_ACK; // RULE_24
                                next_s.sda_oe = 1'b1;
                            end else begin
                                next_s.st = pmsl_pkg::ST_IDLE;
                            end
                        end else begin
                            // every byte goes up; the check byte is flagged, never required
                            next_s.push = 1'b1; // RULE_07
                            next_s.pdata.data = s.sh;
                            next_s.pdata.cmd = s.is_cmd;
                            next_s.pdata.vendor = s.is_cmd && s.sh >= `PMSL_VENDOR_LO &&
                                s.sh <= `PMSL_VENDOR_HI; // RULE_23
                            next_s.pdata.bcast = s.bcast;
                            next_s.pdata.crc_ok = pmsl_crc8(s.crc, s.sh) == 8'h00; // RULE_10
                            next_s.is_cmd = 1'b0;
                            next_s.st = pmsl_pkg::ST_ACK; // RULE_18
                            next_s.sda_oe = 1'b1;
                        end
                    end
                end
                pmsl_pkg::ST_ACK: begin
                    // the ninth bit ends on this fall; only now may the clock be held
                    if (fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.st = pmsl_pkg::ST_HOLD;
                        next_s.scl_oe = 1'b1; // RULE_04
                        next_s.hold_cnt = '0;
                        next_s.to_tx = s.rw && s.is_addr;
                        next_s.tx_rdy = s.rw && s.is_addr;
                        next_s.is_cmd = s.is_addr && !s.rw;
                        next_s.is_addr = 1'b0;
                    end
                end
                pmsl_pkg::ST_HOLD: begin
                    next_s.hold_cnt = s.hold_cnt + 1'b1;
                    if (s.to_tx) begin
                        if (s.pec_pend || (tx_valid_i && s.tx_rdy) ||
                            s.hold_cnt == CW'(STRETCH_CYC - 1)) begin
                            // the device sent the last data byte, so it owes the check
                            next_s.pec_pend = !s.pec_pend && tx_valid_i && s.tx_rdy &&
                                tx_data_i.last; // RULE_10
                            next_s.tx_rdy = 1'b0;
                            next_s.sh = tx_byte;
                            next_s.crc = pmsl_crc8(s.crc, tx_byte); // RULE_19
                            next_s.sda_oe = !tx_byte[7];
                            next_s.bits = '0;
                            next_s.st = pmsl_pkg::ST_TX;
                        end
                    end else if (fifo_ready || s.hold_cnt == CW'(STRETCH_CYC - 1)) begin
                        // a full buffer stalls the host, but never past the limit
                        next_s.bits = '0; // RULE_02
                        next_s.st = pmsl_pkg::ST_RX;
                    end
                end
                pmsl_pkg::ST_TX: begin
                    // data moved one cycle before the clock is let go
                    next_s.scl_oe = 1'b0; // RULE_01
                    if (fall) begin
                        if (s.bits == `PMSL_LAST_BIT) begin
                            next_s.st = pmsl_pkg::ST_RACK;
                            next_s.sda_oe = 1'b0;
                        end else begin
                            next_s.sh = {s.sh[6:0], 1'b0};
                            next_s.sda_oe = !s.sh[6];
                            next_s.bits = s.bits + 1'b1;
                        end
                    end
                end
                pmsl_pkg::ST_RACK: begin
                    if (rise) begin
                        next_s.mack = !s.sda;
                    end
                    if (fall) begin
                        if (s.mack) begin
                            next_s.st = pmsl_pkg::ST_HOLD; // RULE_20
                            next_s.scl_oe = 1'b1;
                            next_s.hold_cnt = '0;
                            next_s.to_tx = 1'b1;
                            next_s.tx_rdy = !s.pec_pend;
                        end else begin
                            next_s.st = pmsl_pkg::ST_IDLE; // RULE_19
                        end
                    end
                end
                default: begin
                    next_s.st = pmsl_pkg::ST_IDLE;
                    next_s.sda_oe = 1'b0;
                    next_s.scl_oe = 1'b0;
                end
            endcase
        end

        // a new trigger wins over a clear in the same cycle
        next_s.alert_n = !(ev_rise || (clr ? |ev : !s.alert_n)); // RULE_11 RULE_12 RULE_14
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '0;
            s.st <= pmsl_pkg::ST_IDLE;
            s.alert_n <= 1'b1;
            s.scl_m <= 1'b1;
            s.scl <= 1'b1;
            s.scl_q <= 1'b1;
            s.sda_m <= 1'b1;
            s.sda <= 1'b1;
            s.sda_q <= 1'b1;
            // start as on, so leaving reset is never taken for an off-to-on clear
            s.en_m <= 1'b1;
            s.en <= 1'b1;
            s.en_q <= 1'b1;
            s.op_q <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    pmsl_fifo #(
        .W($bits(pmsl_pkg::pmsl_rx_s)),
        .D(`PMSL_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(s.push),
        .in_data_i(s.pdata),
        .in_ready_o(fifo_ready),
        .out_valid_o(rx_valid_o),
        .out_data_o(rx_data_o),
        .out_ready_i(rx_ready_i)
    );

    // open-drain lines only ever pull low
    assign scl_o = s.low;
    assign sda_o = s.low;
    assign scl_oe_o = s.scl_oe;
    assign sda_oe_o = s.sda_oe;
    assign tx_ready_o = s.tx_rdy;
    assign alert_n_o = s.alert_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_ack_done;
        s.st == pmsl_pkg::ST_ACK ##1 s.st == pmsl_pkg::ST_HOLD;
    endsequence

    sequence s_addr_hit;
        s.st == pmsl_pkg::ST_RX && s.is_addr && fall && s.bits == `PMSL_BYTE_BITS &&
            !lockup && !stop_c && !start_c && s.sh[7:1] == {`PMSL_CTRL_PFX, s.asel};
    endsequence

    a_no_clock_drive: assert property ( // RULE_01
        (s.st != pmsl_pkg::ST_HOLD && $past(s.st) != pmsl_pkg::ST_HOLD) |-> !scl_oe_o)
        else $error("clock held low outside a stretch");

    a_stretch_bound: assert property ( // RULE_02
        (s.st == pmsl_pkg::ST_HOLD && s.hold_cnt == CW'(STRETCH_CYC - 1) && !lockup &&
         !stop_c && !start_c) |=> s.st != pmsl_pkg::ST_HOLD)
        else $error("clock stretch ran past its limit");

    a_stretch_after_ack: assert property ( // RULE_04
        s_ack_done |-> scl_oe_o && !sda_oe_o)
        else $error("stretch did not follow the acknowledge bit");

    a_lockup_abort: assert property ( // RULE_05
        lockup |=> s.st == pmsl_pkg::ST_IDLE && !sda_oe_o && !scl_oe_o && !s.in_xfer)
        else $error("lock-up did not release the bus");

    a_idle_quiet: assert property ( // RULE_25
        (s.st == pmsl_pkg::ST_IDLE && !start_c) |=> s.st == pmsl_pkg::ST_IDLE && !sda_oe_o)
        else $error("left idle without a start");

    a_addr_ack: assert property ( // RULE_24
        s_addr_hit |=> s.st == pmsl_pkg::ST_ACK && sda_oe_o)
        else $error("own address not acknowledged");

    a_data_push: assert property ( // RULE_07
        (s.st == pmsl_pkg::ST_RX && !s.is_addr && fall && s.bits == `PMSL_BYTE_BITS &&
         !lockup && !stop_c && !start_c) |=> s.push ##1 !s.push)
        else $error("written byte not passed on");

    a_pec_append: assert property ( // RULE_10
        (s.st == pmsl_pkg::ST_HOLD && s.to_tx && s.pec_pend && !lockup && !stop_c &&
         !start_c) |=> s.st == pmsl_pkg::ST_TX && s.sh == $past(s.crc))
        else $error("check byte not sent after last data byte");

    a_alert_latch: assert property ( // RULE_11
        ev_rise |=> !alert_n_o ##1 (!alert_n_o || $past(clr)))
        else $error("alert not latched low on a change");

    a_alert_clear: assert property ( // RULE_14
        (clr && !(|ev) && !ev_rise) |=> alert_n_o)
        else $error("alert not released by a clear");

    a_alert_relatch: assert property ( // RULE_12
        (clr && |ev) |=> !alert_n_o)
        else $error("alert dropped while the alarm persists");
endmodule

// ===== testbench/pmsl_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// host bus master model
// ----------------------------------------
module pmsl_host (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    logic [7:0] crc;

    // lines released at time zero: bus idles high on its pull-ups
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        crc = 8'h00;
    end

    // check byte update, generator x^8+x^2+x+1
    function automatic logic [7:0] nx(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
        return r;
    endfunction

    // one bit from scl low to scl low; a stretch holds the high phase off
    task bt(input logic b, output logic r);
        #31 sda_oe_o = !b;
        #32 scl_oe_o = 1'b0;
        wait (scl_i === 1'b1);
        #31 r = sda_i;
        #31 scl_oe_o = 1'b1;
    endtask

    // start or repeated start; crc is kept across a repeated start
    // pacing after an alert and between reads is scaled far down here
    task st();
        #31 sda_oe_o = 1'b0;
        #31 scl_oe_o = 1'b0;
        wait (scl_i === 1'b1);
        #62 sda_oe_o = 1'b1;
        #62 scl_oe_o = 1'b1;
    endtask

    task sp();
        #31 sda_oe_o = 1'b1;
        #31 scl_oe_o = 1'b0;
        wait (scl_i === 1'b1);
        #62 sda_oe_o = 1'b0;
        #62;
    endtask

    // every byte on the wire enters the running check byte
    task wb(input logic [7:0] d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bt(d[i], r);
        bt(1'b1, r);
        a = !r;
        crc = nx(crc, d);
    endtask

    // host acks or not-acks each read byte as nak says; t_stall not-acks a data byte
    task rb(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bt(1'b1, r);
            d[i] = r;
        end
        bt(nak, r);
        crc = nx(crc, d);
    endtask
endmodule

// ===== testbench/tb_pmsl_slave.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end

module tb_pmsl_slave;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic en = 1'b1;
    logic op = 1'b1;
    logic clr = 1'b0;
    logic swr = 1'b0;
    logic rdy = 1'b1;
    logic txv = 1'b1;
    logic [1:0] ti = 2'h0;
    pmsl_pkg::pmsl_ev_s ev = '0;
    pmsl_pkg::pmsl_tx_s txd;
    pmsl_pkg::pmsl_rx_s rxd;
    pmsl_pkg::pmsl_rx_s rxq[$];
    logic h_scl, h_sda, d_scl, d_sda, d_sclo, d_sdao, rxv, txr, alert_n;
    // open-drain lines: low while a side enables a zero onto them
    wire scl = ~(h_scl | (d_scl & ~d_sclo));
    wire sda = ~(h_sda | (d_sda & ~d_sdao));
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    // read data source: low byte then high byte marked last
    assign txd = (ti != 2'h0) ? 9'h025 : 9'h068;
    always @(posedge clk) begin
        if (txv & txr) ti <= ti + 2'h1;
        if (rxv & rdy) rxq.push_back(rxd);
    end

    pmsl_slave #(.STRETCH_CYC(200), .LOCKUP_CYC(300)) i_dut (
        .clk_i(clk), .srst_i(srst), .scl_i(scl), .scl_o(d_sclo), .scl_oe_o(d_scl),
        .sda_i(sda), .sda_o(d_sdao), .sda_oe_o(d_sda), .addr_select_bit2_i(1'b1),
        .addr_select_bit1_i(1'b0), .addr_select_bit0_i(1'b1),
        .output_enable_pin_i(en), .op_on_i(op), .clear_faults_i(clr),
        .status_word_read_i(swr), .ev_i(ev), .rx_valid_o(rxv), .rx_data_o(rxd),
        .rx_ready_i(rdy), .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr),
        .alert_n_o(alert_n));

    pmsl_host i_host (.scl_i(scl), .sda_i(sda), .scl_oe_o(h_scl), .sda_oe_o(h_sda));

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // the four ways to clear the latched alert
    task clrk(input int k);
        case (k)
            0: clr = 1'b1;
            1: swr = 1'b1;
            2: op = 1'b0;
            default: en = 1'b0;
        endcase
        cyc(6);
        {clr, swr, op, en} = 4'h3;
        cyc(8);
    endtask

    task t_refuse();
        logic a;
        logic [7:0] ad[4] = '{8'hAA, 8'h01, 8'hB2, 8'h00};
        rxq.delete();
        for (int i = 0; i < 4; i++) begin
            i_host.st();
            i_host.wb(ad[i], a);
            `CHK("addr ack", i == 3, a)
            if (i == 3) i_host.wb(8'h03, a);
            i_host.sp();
        end
        cyc(10);
        `CHK("bcast", 3'h7, {rxq.size() == 1, rxq[0].cmd, rxq[0].bcast})
    endtask

    // nothing offered to send: the stretch runs out and an idle byte goes out
    task t_stall();
        logic a;
        logic [7:0] d;
        cyc(1);
        txv = 1'b0;
        i_host.st();
        i_host.wb(8'hBB, a);
        i_host.rb(1'b1, d);
        i_host.sp();
        cyc(1);
        txv = 1'b1;
        `CHK("stall byte", 8'hFF, d)
    endtask

    task t_write();
        logic a;
        logic [7:0] w[4] = '{8'hBA, 8'hD4, 8'h34, 8'h12};
        rxq.delete();
        i_host.crc = 8'h00;
        i_host.st();
        foreach (w[i]) begin
            i_host.wb(w[i], a);
            `CHK("wr ack", 1'b1, a)
        end
        i_host.wb(i_host.crc, a);
        `CHK("pec ack", 1'b1, a)
        i_host.sp();
        cyc(10);
        `CHK("rx count", 4, rxq.size())
        `CHK("cmd", 10'h353, {rxq[0].data, rxq[0].cmd, rxq[0].vendor})
        `CHK("crc ok", 2'b01, {rxq[2].crc_ok, rxq[3].crc_ok})
    endtask

    task t_read();
        logic a;
        logic [7:0] lo, hi, p, e;
        i_host.crc = 8'h00;
        i_host.st();
        i_host.wb(8'hBA, a);
        i_host.wb(8'h8B, a);
        i_host.st();
        i_host.wb(8'hBB, a);
        `CHK("rd ack", 1'b1, a)
        i_host.rb(1'b0, lo);
        i_host.rb(1'b0, hi);
        e = i_host.crc;
        i_host.rb(1'b1, p);
        i_host.sp();
        `CHK("rd data", 16'h1234, {hi, lo})
        `CHK("rd pec", e, p)
    endtask

    task t_alert();
        for (int i = 0; i < 9; i++) begin
            ev = 9'h001 << i;
            cyc(3);
            `CHK("alert set", 1'b0, alert_n)
            clrk(i % 4);
            `CHK("alert again", 1'b0, alert_n)
            ev = '0;
            clrk(i % 4);
            `CHK("alert clr", 1'b1, alert_n)
        end
    endtask

    // host stalls with scl low past the lock-up limit
    task t_lock();
        logic a;
        i_host.st();
        i_host.wb(8'hBA, a);
        cyc(400);
        `CHK("lock oe", 2'b00, {d_scl, d_sda})
        `CHK("lock alert", 1'b0, alert_n)
        i_host.scl_oe_o = 1'b0;
        cyc(10);
        clrk(0);
    endtask

    task wrap_up();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a hang in a bus wait ends the run here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        cyc(20);
        srst = 1'b0;
        cyc(5);
        t_refuse();
        t_write();
        t_read();
        t_stall();
        t_alert();
        t_lock();
        t_write();
        wrap_up();
    end
endmodule
